// File: logic/ias_adc_slave.sv
`timescale 1ns/1ps
module ias_adc_slave
	import ias_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic cmp_hi,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	output logic track,
	output logic mux_pos,
	output logic mux_neg,
	output logic mux_neg_gnd,
	output logic [11:0] dac_code,
	output logic [11:0] result,
	output logic result_valid,
	output logic hs_mode,
	output logic ext_clock,
	output logic polarity_select,
	output logic input_mode_select,
	output logic channel_pick
);
	localparam int STRETCH_MAX = 100;

	ias_state_t state_q;
	ias_state_t state_d;
	logic [1:0] pin_lvl;
	logic [1:0] pin_rise;
	logic [1:0] pin_fall;
	logic [3:0] bit_q;
	logic [7:0] sr_q;
	logic [7:0] tx_q;
	logic rw_q;
	logic lo_next_q;
	logic first_byte_q;
	logic master_ack_q;
	logic sda_oe_q;
	logic scl_oe_q;
	logic track_q;
	logic hs_q;
	logic ext_q;
	logic pol_q;
	logic sgl_q;
	logic cs_q;
	logic mux_pos_q;
	logic mux_neg_q;
	logic mux_gnd_q;
	logic valid_q;
	logic conv_ext_q;
	logic [3:0] osc_q;

	ias_conv_if conv ();

	ias_pin_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pin_in({sda_i, scl_i}),
		.level(pin_lvl),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	ias_sar u_sar (
		.clk(clk),
		.reset(reset),
		.conv(conv.sar)
	);

	////////////////////////////////////////////////////////////////
	wire scl_lvl = pin_lvl[PIN_SCL];
	wire sda_lvl = pin_lvl[PIN_SDA];
	wire scl_rise = pin_rise[PIN_SCL];
	wire scl_fall = pin_fall[PIN_SCL];
	// Any SDA edge with SCL high is a condition, never data
	wire bus_start = pin_fall[PIN_SDA] & scl_lvl;
	wire bus_stop = pin_rise[PIN_SDA] & scl_lvl;
	wire bus_evt = bus_start | bus_stop;
	wire in_addr = state_q == ST_ADDR;
	wire eighth_rise = in_addr & scl_rise & (bit_q == BIT_LAST);
	wire addr_hit_now = sr_q[6:0] == SLAVE_ADDR;
	wire byte_done = scl_fall & (bit_q == BYTE_BITS);
	wire addr_hit = sr_q[7:1] == SLAVE_ADDR;
	wire hs_code = sr_q[7:3] == HS_CODE_TOP;
	wire shift_in = scl_rise & (in_addr | (state_q == ST_WDATA));
	wire track_int = eighth_rise & addr_hit_now & sda_lvl & ~ext_q;
	wire track_ext = eighth_rise & addr_hit_now & sda_lvl & ext_q;
	wire ack_fall = (state_q == ST_ACK) & scl_fall & ~bus_evt;
	wire hold_int = ack_fall & rw_q & ~ext_q;
	wire hold_ext = (state_q == ST_RDATA) & scl_rise & first_byte_q
		& (bit_q == HOLD_PULSE) & ext_q;
	wire wack_fall = (state_q == ST_WACK) & scl_fall & ~bus_evt;
	wire rack_fall = (state_q == ST_RACK) & scl_fall & ~bus_evt;
	wire stretch_done = scl_oe_q & valid_q;
	wire rd_shift = (state_q == ST_RDATA) & scl_fall & ~bus_evt;
	wire load_tx = (ack_fall & rw_q & ~hold_int) | (rack_fall & master_ack_q)
		| stretch_done;
	wire [7:0] tx_next = lo_next_q ? conv.result[7:0] : {RD_PAD, conv.result[11:8]};
	wire osc_tick = osc_q == OSC_DIV - 4'h1;
	wire cfg_sgl_bit = sr_q[SGL_POS];
	wire [3:0] bit_inc = bit_q + 4'h1;

	assign conv.start = hold_int | hold_ext;
	// Internal conversions run off the divided oscillator, external ones off SCL
	assign conv.step = conv_ext_q ? scl_rise : osc_tick;
	assign conv.cmp_hi = cmp_hi;
	assign conv.bipolar = pol_q & ~sgl_q;

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_d = state_q;
		if (bus_stop)
		begin
			state_d = ST_IDLE;
		end
		else if (bus_start)
		begin
			state_d = ST_ADDR;
		end
		else if (scl_fall)
		begin
			unique case (state_q)
				ST_IDLE: state_d = ST_IDLE;
				ST_ADDR:
				begin
					if (bit_q == BYTE_BITS)
					begin
						state_d = addr_hit ? ST_ACK : (hs_code ? ST_HSNACK : ST_SKIP);
					end
				end
				ST_ACK: state_d = rw_q ? ST_RDATA : ST_WDATA;
				ST_WDATA: state_d = (bit_q == BYTE_BITS) ? ST_WACK : ST_WDATA;
				ST_WACK: state_d = ST_WDATA;
				ST_RDATA: state_d = (bit_q == BIT_LAST) ? ST_RACK : ST_RDATA;
				ST_RACK: state_d = master_ack_q ? ST_RDATA : ST_SKIP;
				ST_HSNACK: state_d = ST_SKIP;
				ST_SKIP: state_d = ST_SKIP;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			if ((state_d != state_q) | bus_start)
			begin
				bit_q <= 4'h0;
			end
			else if (shift_in | rd_shift)
			begin
				bit_q <= bit_inc;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sr_q <= 8'h00;
			rw_q <= 1'h0;
			master_ack_q <= 1'h0;
		end
		else
		begin
			if (shift_in)
			begin
				sr_q <= {sr_q[6:0], sda_lvl};
			end
			if (eighth_rise)
			begin
				rw_q <= sda_lvl;
			end
			if ((state_q == ST_RACK) & scl_rise)
			begin
				master_ack_q <= ~sda_lvl;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// SDA only moves while SCL is low, or on a condition
	always_ff @(posedge clk)
	begin
		if (reset | bus_evt)
		begin
			sda_oe_q <= 1'h0;
		end
		else if (load_tx)
		begin
			sda_oe_q <= ~tx_next[7];
		end
		else if (scl_fall)
		begin
			unique case (state_q)
				ST_ADDR: sda_oe_q <= (bit_q == BYTE_BITS) & addr_hit;
				ST_WDATA: sda_oe_q <= bit_q == BYTE_BITS;
				ST_RDATA: sda_oe_q <= (bit_q != BIT_LAST) & ~tx_q[6];
				default: sda_oe_q <= 1'h0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_q <= 8'h00;
			lo_next_q <= 1'h0;
			first_byte_q <= 1'h0;
		end
		else
		begin
			if (bus_start)
			begin
				lo_next_q <= 1'h0;
			end
			else if (load_tx)
			begin
				tx_q <= tx_next;
				lo_next_q <= ~lo_next_q;
			end
			else if (rd_shift)
			begin
				tx_q <= {tx_q[6:0], 1'h0};
			end
			first_byte_q <= ack_fall ? rw_q : (first_byte_q & ~rack_fall);
		end
	end

	////////////////////////////////////////////////////////////////
	// Stretch ends two cycles after done so the new result is loaded first
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			scl_oe_q <= 1'h0;
			track_q <= 1'h0;
			conv_ext_q <= 1'h0;
			osc_q <= 4'h0;
			valid_q <= 1'h0;
		end
		else
		begin
			scl_oe_q <= hold_int | (scl_oe_q & ~valid_q);
			track_q <= (track_q | track_int | track_ext) & ~conv.start;
			if (conv.start)
			begin
				conv_ext_q <= ext_q;
			end
			osc_q <= (conv.busy & ~osc_tick) ? osc_q + 4'h1 : 4'h0;
			valid_q <= conv.done;
		end
	end

	////////////////////////////////////////////////////////////////
	// Settings only land once the byte's ack pulse has passed
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ext_q <= EXT_RST;
			pol_q <= POL_RST;
			sgl_q <= SGL_RST;
			cs_q <= CS_RST;
			hs_q <= 1'h0;
		end
		else
		begin
			if (wack_fall & sr_q[REG_FLAG_POS])
			begin
				ext_q <= sr_q[CLK_POS];
				pol_q <= sr_q[POL_POS];
				if (!sr_q[RST_POS])
				begin
					sgl_q <= SGL_RST;
					cs_q <= CS_RST;
				end
			end
			else if (wack_fall)
			begin
				cs_q <= sr_q[CS_POS];
				sgl_q <= cfg_sgl_bit;
			end
			if (bus_stop)
			begin
				hs_q <= 1'h0;
			end
			else if ((state_q == ST_HSNACK) & scl_fall & ~bus_start)
			begin
				hs_q <= 1'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mux_pos_q <= CS_RST;
			mux_neg_q <= ~CS_RST;
			mux_gnd_q <= SGL_RST;
		end
		else
		begin
			mux_pos_q <= cs_q;
			mux_neg_q <= ~cs_q;
			mux_gnd_q <= sgl_q;
		end
	end

	assign scl_o = 1'h0;
	assign sda_o = 1'h0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign track = track_q;
	assign mux_pos = mux_pos_q;
	assign mux_neg = mux_neg_q;
	assign mux_neg_gnd = mux_gnd_q;
	assign dac_code = conv.trial;
	assign result = conv.result;
	assign result_valid = valid_q;
	assign hs_mode = hs_q;
	assign ext_clock = ext_q;
	assign polarity_select = pol_q;
	assign input_mode_select = sgl_q;
	assign channel_pick = cs_q;

	////////////////////////////////////////////////////////////////
	sequence s_int_read_held;
		ack_fall && rw_q && !ext_q;
	endsequence
	sequence s_stretch_open;
		scl_oe_q && !track_q;
	endsequence
	sequence s_cfg_taken;
		wack_fall && !sr_q[REG_FLAG_POS];
	endsequence

	chk_track_internal: assert property (@(posedge clk) disable iff (reset)
		track_int |=> track_q)
		else $error("tracking did not start on eighth address rise");
	chk_hold_stretch: assert property (@(posedge clk) disable iff (reset)
		s_int_read_held |=> s_stretch_open ##0 conv.busy)
		else $error("hold and stretch missing after address ack");
	chk_stretch_bound: assert property (@(posedge clk) disable iff (reset)
		$rose(scl_oe_q) |-> ##[1:STRETCH_MAX] !scl_oe_q)
		else $error("clock stretch did not end");
	chk_stretch_end: assert property (@(posedge clk) disable iff (reset)
		scl_oe_q && valid_q |=> !scl_oe_q && tx_q == {RD_PAD, result[11:8]} ##0 sda_oe_q == ~tx_q[7])
		else $error("stretch release without result byte");
	chk_track_external: assert property (@(posedge clk) disable iff (reset)
		track_ext |=> track_q && !conv.busy)
		else $error("external tracking not started on read bit");
	chk_hold_external: assert property (@(posedge clk) disable iff (reset)
		hold_ext |=> !track_q && conv.busy && conv_ext_q)
		else $error("external hold not taken on second pulse");
	chk_addr_ack: assert property (@(posedge clk) disable iff (reset)
		state_q == ST_ACK |-> sda_oe_q)
		else $error("matched address not acknowledged");
	chk_skip_quiet: assert property (@(posedge clk) disable iff (reset)
		state_q == ST_SKIP || state_q == ST_HSNACK |-> !sda_oe_q)
		else $error("SDA driven while ignoring the bus");
	chk_sda_stable: assert property (@(posedge clk) disable iff (reset)
		$changed(sda_oe_q) |-> !$past(scl_lvl) || $past(bus_evt))
		else $error("SDA changed while SCL high");
	chk_hs_enter: assert property (@(posedge clk) disable iff (reset)
		state_q == ST_HSNACK && scl_fall && !bus_evt |=> hs_q)
		else $error("high-speed mode not entered");
	chk_stop_fs: assert property (@(posedge clk) disable iff (reset)
		bus_stop |=> !hs_q)
		else $error("stop did not leave high-speed mode");
	chk_rstart_keep: assert property (@(posedge clk) disable iff (reset)
		bus_start |=> hs_q == $past(hs_q))
		else $error("repeated start changed speed mode");
	chk_cfg_apply: assert property (@(posedge clk) disable iff (reset)
		s_cfg_taken |=> sgl_q == $past(cfg_sgl_bit))
		else $error("configuration byte not applied");
endmodule

// File: logic/ias_conv_if.sv
`timescale 1ns/1ps
interface ias_conv_if;
	logic start;
	logic step;
	logic cmp_hi;
	logic bipolar;
	logic busy;
	logic done;
	logic [11:0] trial;
	logic [11:0] result;

	modport seq (output start, step, cmp_hi, bipolar, input busy, done, trial, result);
	modport sar (input start, step, cmp_hi, bipolar, output busy, done, trial, result);
endinterface

// File: logic/ias_pin_sync.sv
`timescale 1ns/1ps
module ias_pin_sync
	import ias_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] pin_in,
	output logic [1:0] level,
	output logic [1:0] rise,
	output logic [1:0] fall
);
	////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			logic meta_q;
			logic lvl_q;
			logic prev_q;
			// Idle-high reset keeps a false stop from firing at release
			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					meta_q <= PIN_IDLE;
					lvl_q <= PIN_IDLE;
					prev_q <= PIN_IDLE;
				end
				else
				begin
					meta_q <= pin_in[gi];
					lvl_q <= meta_q;
					prev_q <= lvl_q;
				end
			end
			assign level[gi] = lvl_q;
			assign rise[gi] = lvl_q & ~prev_q;
			assign fall[gi] = ~lvl_q & prev_q;
		end
	endgenerate
endmodule

// File: logic/ias_pkg.sv
package ias_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h36;
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] HOLD_PULSE = 4'h1;
	localparam logic [3:0] SAR_TOP = 4'hb;
	localparam logic [11:0] SAR_FIRST = 12'h800;
	localparam logic [3:0] RD_PAD = 4'hf;
	localparam int REG_FLAG_POS = 7;
	localparam int CLK_POS = 3;
	localparam int POL_POS = 2;
	localparam int RST_POS = 1;
	localparam int CS_POS = 1;
	localparam int SGL_POS = 0;
	localparam logic EXT_RST = 1'h0;
	localparam logic POL_RST = 1'h0;
	localparam logic SGL_RST = 1'h1;
	localparam logic CS_RST = 1'h0;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam logic PIN_IDLE = 1'h1;
	localparam int CLK_PERIOD_NS = 20;
	localparam int OSC_PERIOD_NS = 80;
	localparam logic [3:0] OSC_DIV = 4'(OSC_PERIOD_NS / CLK_PERIOD_NS);

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ACK = 9'h004,
		ST_WDATA = 9'h008,
		ST_WACK = 9'h010,
		ST_RDATA = 9'h020,
		ST_RACK = 9'h040,
		ST_HSNACK = 9'h080,
		ST_SKIP = 9'h100
	} ias_state_t;
endpackage

// File: logic/ias_sar.sv
`timescale 1ns/1ps
module ias_sar
	import ias_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	ias_conv_if.sar conv
);
	logic [11:0] trial_q;
	logic [11:0] trial_d;
	logic [11:0] result_q;
	logic [3:0] idx_q;
	logic [3:0] steps_q;
	logic busy_q;
	logic done_q;
	logic bip_q;

	////////////////////////////////////////////////////////////////
	wire step_ok = conv.step & busy_q & ~conv.start;
	wire last_step = step_ok & (idx_q == 4'h0);
	// Offset binary flips its top bit into two's complement
	wire [11:0] formatted = bip_q ? {~trial_d[11], trial_d[10:0]} : trial_d;

	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++)
		begin : g_bit
			assign trial_d[gi] = conv.start ? SAR_FIRST[gi] :
				(step_ok & (idx_q == 4'(gi))) ? conv.cmp_hi :
				(step_ok & (idx_q == 4'(gi + 1))) ? 1'h1 : trial_q[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			trial_q <= 12'h000;
			idx_q <= 4'h0;
			busy_q <= 1'h0;
			bip_q <= 1'h0;
		end
		else
		begin
			trial_q <= trial_d;
			busy_q <= conv.start | (busy_q & ~last_step);
			if (conv.start)
			begin
				idx_q <= SAR_TOP;
				bip_q <= conv.bipolar;
			end
			else if (step_ok & ~last_step)
			begin
				idx_q <= idx_q - 4'h1;
			end
		end
	end

	// In unipolar mode a negative differential input fails every trial and reads zero
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			result_q <= 12'h000;
			done_q <= 1'h0;
		end
		else
		begin
			done_q <= last_step;
			if (last_step)
			begin
				result_q <= formatted;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset | conv.start)
		begin
			steps_q <= 4'h0;
		end
		else if (step_ok)
		begin
			steps_q <= steps_q + 4'h1;
		end
	end

	assign conv.busy = busy_q;
	assign conv.done = done_q;
	assign conv.trial = trial_q;
	assign conv.result = result_q;

	////////////////////////////////////////////////////////////////
	chk_sar_twelve_steps: assert property (@(posedge clk) disable iff (reset)
		conv.done |-> steps_q == 4'hc)
		else $error("conversion did not take twelve steps");
	chk_unipolar_binary: assert property (@(posedge clk) disable iff (reset)
		conv.done && !bip_q |-> result_q == trial_q)
		else $error("unipolar result not straight binary");
	chk_bipolar_msb: assert property (@(posedge clk) disable iff (reset)
		conv.done && bip_q |-> result_q[11] != trial_q[11])
		else $error("bipolar result not two's complement");
endmodule

// File: verif/ias_master_model.sv
`timescale 1ns/1ps
module ias_master_model (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low,
	output logic hang
);
	initial
	begin
		scl_low = 1'h0;
		sda_low = 1'h0;
		hang = 1'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// The slave may stretch SCL; a stuck line ends the run instead of hanging it
	task automatic scl_up();
		int n;
		n = 0;
		scl_low = 1'h0;
		tick(1);
		while (scl !== 1'h1 && n < 2000)
		begin
			tick(1);
			n++;
		end
		if (n >= 2000)
			hang = 1'h1;
	endtask

	task automatic start();
		sda_low = 1'h0;
		tick(2);
		scl_up();
		tick(3);
		sda_low = 1'h1;
		tick(4);
		scl_low = 1'h1;
		tick(2);
	endtask

	task automatic stop();
		sda_low = 1'h1;
		tick(2);
		scl_up();
		tick(3);
		sda_low = 1'h0;
		tick(6);
	endtask

	// SDA only moves well after SCL has fallen, so the slave never sees it as a condition
	// Eight clk ticks per bit give the 160 ns SCL period
	task automatic bit_xfer(input logic b, output logic got);
		sda_low = ~b;
		tick(2);
		scl_up();
		tick(2);
		got = sda;
		tick(1);
		scl_low = 1'h1;
		tick(2);
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		logic b;
		for (int i = 7; i >= 0; i--)
		begin
			bit_xfer(tx[i], b);
			rx[i] = b;
		end
		bit_xfer(ack_in, ack_out);
	endtask
endmodule

// File: verif/tb_i2c_adc_slave_control.sv
`timescale 1ns/1ps
module tb_i2c_adc_slave_control
	import ias_pkg::*;
();
	logic clk, reset, cmp_hi, scl_oe, sda_oe, track, mux_pos, mux_neg, mux_neg_gnd;
	logic result_valid, hs_mode, ext_clock, polarity_select, input_mode_select, channel_pick;
	logic [11:0] dac_code, result, vin, prev;
	logic m_scl_low, m_sda_low, hang, scl_w, sda_w, ak, hold_bad, scl_o, sda_o;
	logic [7:0] rx;
	int trk_n, str_n, vld_n, err_count, n_compared;
	// Write rows: data byte, then expected clock, polarity, input mode, channel
	logic [11:0] wrow [6] = '{12'h000, 12'h033, 12'h021, 12'h8ed, 12'h802, 12'h012};
	logic [7:0] bad [2] = '{8'h6e, 8'hec};
	// Read rows: config, setup, held input, expected result
	logic [39:0] rrow [4] = '{{8'h01, 8'h86, 12'h5a3, 12'h5a3}, {8'h00, 8'h86, 12'h5a3, 12'hda3},
		{8'h00, 8'h82, 12'h000, 12'h000}, {8'h03, 8'h8a, 12'h3c7, 12'h3c7}};

	// Open-drain wires: a driving party shows its pin value, a released line pulls up
	assign scl_w = (scl_oe ? scl_o : 1'h1) & !m_scl_low;
	assign sda_w = (sda_oe ? sda_o : 1'h1) & !m_sda_low;

	ias_adc_slave ias_adc_slave_i (
		.clk(clk),
		.reset(reset),
		.scl_i(scl_w),
		.sda_i(sda_w),
		.cmp_hi(cmp_hi),
		.scl_o(scl_o),
		.scl_oe(scl_oe),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.track(track),
		.mux_pos(mux_pos),
		.mux_neg(mux_neg),
		.mux_neg_gnd(mux_neg_gnd),
		.dac_code(dac_code),
		.result(result),
		.result_valid(result_valid),
		.hs_mode(hs_mode),
		.ext_clock(ext_clock),
		.polarity_select(polarity_select),
		.input_mode_select(input_mode_select),
		.channel_pick(channel_pick)
	);

	ias_master_model ias_master_model_i (
		.clk(clk),
		.scl(scl_w),
		.sda(sda_w),
		.scl_low(m_scl_low),
		.sda_low(m_sda_low),
		.hang(hang)
	);

	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// Comparator stand-in; a negative differential input never beats any trial code
	always @(negedge clk)
		cmp_hi <= (vin >= dac_code);

	always @(posedge clk)
	begin
		if (track)
			trk_n <= trk_n + 1;
		if (scl_oe)
			str_n <= str_n + 1;
		if (result_valid)
			vld_n <= vld_n + 1;
		if (scl_oe && track)
			hold_bad <= 1'h1;
	end

	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		n_compared++;
		if (seen !== want)
		begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask

	task automatic close_out();
		$display("compared %0d, mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge hang)
	begin
		err_count++;
		close_out();
	end

	task automatic ck_cfg(input logic [3:0] e);
		check({8'h0, ext_clock, polarity_select, input_mode_select, channel_pick}, {8'h0, e});
		check({9'h0, mux_neg_gnd, mux_pos, mux_neg}, {9'h0, e[1], e[0], ~e[0]});
	endtask

	task automatic wr_cycle(input logic [7:0] a, input logic [7:0] d, input logic match);
		ias_master_model_i.start();
		ias_master_model_i.xfer(a, 1'h1, rx, ak);
		check(12'(ak), 12'(!match));
		ias_master_model_i.xfer(d, 1'h1, rx, ak);
		check(12'(ak), 12'(!match));
		ias_master_model_i.stop();
		ias_master_model_i.tick(4);
	endtask

	task automatic rd_cycle(input logic [11:0] p);
		ias_master_model_i.start();
		ias_master_model_i.xfer({SLAVE_ADDR, 1'h1}, 1'h1, rx, ak);
		check(12'(ak), 12'h0);
		ias_master_model_i.xfer(8'hff, 1'h0, rx, ak);
		check({4'h0, rx}, {8'h0f, p[11:8]});
		ias_master_model_i.xfer(8'hff, 1'h1, rx, ak);
		check({4'h0, rx}, {4'h0, p[7:0]});
		ias_master_model_i.stop();
		ias_master_model_i.tick(4);
	endtask

	initial
	begin
		err_count = 0;
		n_compared = 0;
		vin = 12'h000;
		cmp_hi = 1'h0;
		trk_n = 0;
		str_n = 0;
		vld_n = 0;
		hold_bad = 1'h0;
		reset = 1'h1;
		repeat (4) @(negedge clk);
		reset = 1'h0;
		ias_master_model_i.tick(4);
		ck_cfg(4'h2);
		for (int i = 0; i < 6; i++)
		begin
			wr_cycle({SLAVE_ADDR, 1'h0}, wrow[i][11:4], 1'h1);
			ck_cfg(wrow[i][3:0]);
		end
		for (int i = 0; i < 2; i++)
		begin
			wr_cycle(bad[i], 8'h00, 1'h0);
			ck_cfg(4'h2);
		end
		// High-speed entry, repeated start keeps it, stop drops it
		ias_master_model_i.start();
		ias_master_model_i.xfer(8'h0b, 1'h1, rx, ak);
		check(12'(ak), 12'h1);
		ias_master_model_i.tick(4);
		check(12'(hs_mode), 12'h1);
		ias_master_model_i.start();
		ias_master_model_i.xfer({SLAVE_ADDR, 1'h0}, 1'h1, rx, ak);
		ias_master_model_i.xfer(8'h03, 1'h1, rx, ak);
		check(12'(ak), 12'h0);
		ias_master_model_i.xfer(8'h8e, 1'h1, rx, ak);
		check(12'(ak), 12'h0);
		check(12'(hs_mode), 12'h1);
		ias_master_model_i.stop();
		ias_master_model_i.tick(4);
		check(12'(hs_mode), 12'h0);
		ck_cfg(4'hf);
		// Reset in mid-run from non-default settings
		reset = 1'h1;
		repeat (4) @(negedge clk);
		reset = 1'h0;
		ias_master_model_i.tick(4);
		ck_cfg(4'h2);
		check({10'h0, hs_mode, track}, 12'h0);
		prev = 12'h000;
		for (int i = 0; i < 4; i++)
		begin
			ias_master_model_i.start();
			ias_master_model_i.xfer({SLAVE_ADDR, 1'h0}, 1'h1, rx, ak);
			ias_master_model_i.xfer(rrow[i][39:32], 1'h1, rx, ak);
			ias_master_model_i.xfer(rrow[i][31:24], 1'h1, rx, ak);
			ias_master_model_i.stop();
			vin = rrow[i][23:12];
			// External clock reads shift out the result of the conversion before
			if (!rrow[i][27])
				prev = rrow[i][11:0];
			trk_n = 0;
			str_n = 0;
			vld_n = 0;
			hold_bad = 1'h0;
			rd_cycle(prev);
			check(12'(vld_n), 12'h1);
			check(result, rrow[i][11:0]);
			check(12'(trk_n != 0), 12'h1);
			check(12'(str_n != 0), 12'(!rrow[i][27]));
			check(12'(hold_bad), 12'h0);
			prev = rrow[i][11:0];
		end
		close_out();
	end
endmodule
